// File: rtl/refsc_pkg.sv
package refsc_pkg;

  // Serial bus frame states, Gray coded along idle-addr-data-done.
  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_ADDR = 2'b01,
    SPI_DATA = 2'b11,
    SPI_DONE = 2'b10
  } refsc_spi_state_t;

endpackage

// File: rtl/refsc_regs.svh
`ifndef REFSC_REGS_SVH
`define REFSC_REGS_SVH

// Register offsets on the serial control bus.
`define REFSC_OFF_BIAS_CODE 8'h09
`define REFSC_OFF_MAIN_CLOCK_MHZ_FIELD_CODE 8'h0B
`define REFSC_OFF_AMP_CODE 8'h2C
`define REFSC_OFF_GEN_CTRL 8'h75
`define REFSC_OFF_MCLK_MAIN_CLOCK_MHZ_FIELD 8'h76
`define REFSC_OFF_IRQ_EN 8'h77
`define REFSC_OFF_IRQ_MASK 8'h78
`define REFSC_OFF_RESET_CMD 8'h79
`define REFSC_OFF_LOOP_DIV 8'h7A
`define REFSC_OFF_LO_DIV 8'h7B
`define REFSC_OFF_LO_PWR 8'h7C
`define REFSC_OFF_CLK_DIV 8'h7D
`define REFSC_OFF_OSC_STATUS 8'h83
`define REFSC_OFF_GEN_CTRL_RB 8'hC5
`define REFSC_OFF_MCLK_MAIN_CLOCK_MHZ_FIELD_RB 8'hC6
`define REFSC_OFF_IRQ_EN_RB 8'hC7
`define REFSC_OFF_IRQ_MASK_RB 8'hC8
`define REFSC_OFF_IRQ_STATUS 8'hC9
`define REFSC_OFF_LOOP_DIV_RB 8'hCA
`define REFSC_OFF_LO_DIV_RB 8'hCB
`define REFSC_OFF_LO_PWR_RB 8'hCC
`define REFSC_OFF_CLK_DIV_RB 8'hCD
`define REFSC_OFF_AMP_RB 8'hD6
`define REFSC_OFF_BIAS_RB 8'hD9
`define REFSC_OFF_MAIN_CLOCK_MHZ_FIELD_RB 8'hDB

// Reset values.
`define REFSC_RST_GEN_CTRL 8'h00
`define REFSC_RST_MCLK_MAIN_CLOCK_MHZ_FIELD 6'h26
`define REFSC_RST_IRQ_EN 3'h0
`define REFSC_RST_IRQ_MASK 3'h0
`define REFSC_RST_LOOP_DIV 7'h1F
`define REFSC_RST_LO_DIV 5'h03
`define REFSC_RST_LO_PWR 4'h0
`define REFSC_RST_CLK_DIV 2'h0
`define REFSC_RST_BIAS 5'h10
`define REFSC_RST_MAIN_CLOCK_MHZ_FIELD 9'h102
`define REFSC_RST_AMP 6'h20

// Interrupt bit positions and field positions.
`define REFSC_IRQ_MCLK_READY 0
`define REFSC_IRQ_RETUNE 1
`define REFSC_IRQ_TUNE_DONE 2
`define REFSC_GCR_CAL_BIT 2
`define REFSC_TIMEOUT_BIT 15

`endif

// File: rtl/refsc_top.sv
`timescale 1ns/1ps
`include "refsc_regs.svh"
// Function
// - Serial register access works whether the main clock is on or off.
// - Main clock MHz field is bits 5:0, resets 0x26, valid 10-40.
// - Event is recorded in status only when its enable bit is set.
// - A status bit becoming one clears its matching enable bit.
// - Interrupt pin goes low while any masked status bit is one.
// - Reading the status register returns flags then clears it.
// - Reset command returns all reference registers to defaults.
// - Readbacks C5 to C8 and CA return their control registers.
// - Oscillator status shows four flags in bits 3:0, upper zero.
// - Loop divider is bits 6:0, resets 0x1F, valid 4-127.
// - Bias code is bits 4:0, resets 0x10, drives the oscillator.
// - Frequency code bits 8:0, reset 0x102, timeout flag at bit 15.
// - Calibration timeout also sets retune status when enabled.
// - Timeout flag clears on next calibration start or code write.
// - Amplitude code is bits 5:0 and resets to 0x20.
// - Calibration readbacks update on write or during calibration.
// - LO drive level is bits 3:0, resets 0, codes 13-15 invalid.
// - Clock output ratio bits 1:0, codes 0-2 divide by 1-3.
module refsc_top (
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic SPI_CSN_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_MOSI_IN,
  output logic SPI_MISO_OUT,
  output logic SPI_MISO_OE_OUT,
  input wire logic EV_MCLK_READY_IN,
  input wire logic EV_TUNE_DONE_IN,
  input wire logic EV_CAL_TIMEOUT_IN,
  input wire logic CAL_START_IN,
  input wire logic CAL_UPDATE_IN,
  input wire logic [4:0] CAL_BIAS_IN,
  input wire logic [8:0] CAL_MAIN_CLOCK_MHZ_FIELD_IN,
  input wire logic [5:0] CAL_AMP_IN,
  input wire logic [3:0] OSC_FLAGS_IN,
  output logic IRQ_N_OUT,
  output logic [7:0] GEN_CTRL_OUT,
  output logic [5:0] MCLK_MAIN_CLOCK_MHZ_FIELD_OUT,
  output logic [6:0] LOOP_DIV_OUT,
  output logic [3:0] LO_RATIO_OUT,
  output logic [4:0] LO_DIVIDE_OUT,
  output logic [3:0] LO_DRIVE_OUT,
  output logic [1:0] CLK_RATIO_OUT,
  output logic [4:0] BIAS_CODE_OUT,
  output logic [8:0] MAIN_CLOCK_MHZ_FIELD_CODE_OUT,
  output logic [5:0] AMP_CODE_OUT
);

  refsc_pkg::refsc_spi_state_t state_reg;
  logic [1:0] csn_sync_reg, sclk_sync_reg, mosi_sync_reg;
  logic sclk_prev_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] rx_reg, tx_reg;
  logic [7:0] addr_reg;
  logic rd_reg, wide_reg;
  logic wr_strobe_reg, soft_rst_reg, isr_rd_reg;
  logic [7:0] gcr_reg;
  logic [5:0] mclk_main_clock_mhz_field_reg;
  logic [2:0] ise_reg, ism_reg, isr_reg, ev_set;
  logic [6:0] loop_divider_value_reg;
  logic [4:0] lo_div_reg;
  logic [3:0] lo_pwr_reg;
  logic [1:0] clk_div_reg;
  logic [4:0] bias_reg, bias_rb_reg;
  logic [8:0] main_clock_mhz_field_reg, main_clock_mhz_field_rb_reg;
  logic [5:0] amp_reg, amp_rb_reg;
  logic timeout_reg, irq_n_reg;
  logic sclk_rise, wr_hit_main_clock_mhz_field;
  logic [7:0] addr_full;

  // True for registers that carry sixteen data bits.
  function automatic logic is_wide(input logic [7:0] a);
    is_wide = (a == `REFSC_OFF_MAIN_CLOCK_MHZ_FIELD_CODE) || (a == `REFSC_OFF_MAIN_CLOCK_MHZ_FIELD_RB);
  endfunction

  // True for write-side offsets that accept a data phase.
  function automatic logic is_writable(input logic [7:0] a);
    case (a)
      `REFSC_OFF_BIAS_CODE, `REFSC_OFF_MAIN_CLOCK_MHZ_FIELD_CODE, `REFSC_OFF_AMP_CODE,
      `REFSC_OFF_GEN_CTRL, `REFSC_OFF_MCLK_MAIN_CLOCK_MHZ_FIELD, `REFSC_OFF_IRQ_EN,
      `REFSC_OFF_IRQ_MASK, `REFSC_OFF_LOOP_DIV, `REFSC_OFF_LO_DIV,
      `REFSC_OFF_LO_PWR, `REFSC_OFF_CLK_DIV: is_writable = 1'b1;
      default: is_writable = 1'b0;
    endcase
  endfunction

  // Read mux, left aligned so the first bit out is always bit 15.
  function automatic logic [15:0] read_word(input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      `REFSC_OFF_OSC_STATUS: v = {4'h0, OSC_FLAGS_IN, 8'h00};
      `REFSC_OFF_GEN_CTRL_RB: v = {gcr_reg, 8'h00};
      `REFSC_OFF_MCLK_MAIN_CLOCK_MHZ_FIELD_RB: v = {2'h0, mclk_main_clock_mhz_field_reg, 8'h00};
      `REFSC_OFF_IRQ_EN_RB: v = {5'h00, ise_reg, 8'h00};
      `REFSC_OFF_IRQ_MASK_RB: v = {5'h00, ism_reg, 8'h00};
      `REFSC_OFF_IRQ_STATUS: v = {5'h00, isr_reg, 8'h00};
      `REFSC_OFF_LOOP_DIV_RB: v = {1'b0, loop_divider_value_reg, 8'h00};
      `REFSC_OFF_LO_DIV_RB: v = {3'h0, lo_div_reg, 8'h00};
      `REFSC_OFF_LO_PWR_RB: v = {4'h0, lo_pwr_reg, 8'h00};
      `REFSC_OFF_CLK_DIV_RB: v = {6'h00, clk_div_reg, 8'h00};
      `REFSC_OFF_AMP_RB: v = {2'h0, amp_rb_reg, 8'h00};
      `REFSC_OFF_BIAS_RB: v = {3'h0, bias_rb_reg, 8'h00};
      // The timeout flag rides in bit 15 so the host can see it.
      `REFSC_OFF_MAIN_CLOCK_MHZ_FIELD_RB: v = {timeout_reg, 6'h00, main_clock_mhz_field_rb_reg};
      default: v = 16'h0000;
    endcase
    read_word = v;
  endfunction

  // LO divide ratio decode: 0 gives 1, 15 gives 3, else twice the code.
  function automatic logic [4:0] lo_ratio(input logic [3:0] c);
    if (c == 4'h0) begin
      lo_ratio = 5'h01;
    end else if (c == 4'hF) begin
      lo_ratio = 5'h03;
    end else begin
      lo_ratio = {c, 1'b0};
    end
  endfunction

  // Pins are asynchronous to the system clock, so each takes two flops.
  // The edge detector reads only the second stage and its delayed copy.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      csn_sync_reg <= 2'h3;
      sclk_sync_reg <= 2'h0;
      mosi_sync_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      csn_sync_reg <= {csn_sync_reg[0], SPI_CSN_IN};
      sclk_sync_reg <= {sclk_sync_reg[0], SPI_SCLK_IN};
      mosi_sync_reg <= {mosi_sync_reg[0], SPI_MOSI_IN};
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg & ~csn_sync_reg[1];
  assign addr_full = {rx_reg[6:0], mosi_sync_reg[1]};

  // Frame engine. It runs on the system clock alone and never looks at
  // the main clock enable, so the bus stays usable with that clock off.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_reg <= refsc_pkg::SPI_IDLE;
      bit_cnt_reg <= 5'h00;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      addr_reg <= 8'h00;
      rd_reg <= 1'b0;
      wide_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      isr_rd_reg <= 1'b0;
    end else begin
      wr_strobe_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      isr_rd_reg <= 1'b0;
      if (csn_sync_reg[1]) begin
        state_reg <= refsc_pkg::SPI_IDLE;
        rd_reg <= 1'b0;
      end else begin
        case (state_reg)
          refsc_pkg::SPI_IDLE: begin
            bit_cnt_reg <= 5'h00;
            state_reg <= refsc_pkg::SPI_ADDR;
          end
          refsc_pkg::SPI_ADDR: begin
            if (sclk_rise) begin
              rx_reg <= {rx_reg[14:0], mosi_sync_reg[1]};
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == 5'h07) begin
                addr_reg <= addr_full;
                wide_reg <= is_wide(addr_full);
                bit_cnt_reg <= 5'h00;
                if (addr_full == `REFSC_OFF_RESET_CMD) begin
                  soft_rst_reg <= 1'b1;
                  state_reg <= refsc_pkg::SPI_DONE;
                end else if (addr_full >= 8'h80) begin
                  tx_reg <= read_word(addr_full);
                  rd_reg <= 1'b1;
                  isr_rd_reg <= (addr_full == `REFSC_OFF_IRQ_STATUS);
                  state_reg <= refsc_pkg::SPI_DATA;
                end else if (is_writable(addr_full)) begin
                  state_reg <= refsc_pkg::SPI_DATA;
                end else begin
                  state_reg <= refsc_pkg::SPI_DONE;
                end
              end
            end
          end
          refsc_pkg::SPI_DATA: begin
            if (sclk_rise) begin
              rx_reg <= {rx_reg[14:0], mosi_sync_reg[1]};
              tx_reg <= {tx_reg[14:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == (wide_reg ? 5'h0F : 5'h07)) begin
                wr_strobe_reg <= ~rd_reg;
                rd_reg <= 1'b0;
                state_reg <= refsc_pkg::SPI_DONE;
              end
            end
          end
          refsc_pkg::SPI_DONE: begin
            state_reg <= refsc_pkg::SPI_DONE;
          end
          default: begin
            state_reg <= refsc_pkg::SPI_IDLE;
          end
        endcase
      end
    end
  end

  // Reply pin: most significant bit first, driven only during a read.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      SPI_MISO_OUT <= 1'b0;
      SPI_MISO_OE_OUT <= 1'b0;
    end else begin
      SPI_MISO_OUT <= tx_reg[15];
      SPI_MISO_OE_OUT <= rd_reg & ~csn_sync_reg[1];
    end
  end

  // A narrow write carries its byte in the low eight received bits.
  function automatic logic hit(input logic [7:0] a);
    hit = wr_strobe_reg && (addr_reg == a);
  endfunction

  assign wr_hit_main_clock_mhz_field = hit(`REFSC_OFF_MAIN_CLOCK_MHZ_FIELD_CODE);

  // Plain control registers. The reset command restores them all.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      mclk_main_clock_mhz_field_reg <= `REFSC_RST_MCLK_MAIN_CLOCK_MHZ_FIELD;
      ism_reg <= `REFSC_RST_IRQ_MASK;
      loop_divider_value_reg <= `REFSC_RST_LOOP_DIV;
      lo_div_reg <= `REFSC_RST_LO_DIV;
      lo_pwr_reg <= `REFSC_RST_LO_PWR;
      clk_div_reg <= `REFSC_RST_CLK_DIV;
    end else if (soft_rst_reg) begin
      mclk_main_clock_mhz_field_reg <= `REFSC_RST_MCLK_MAIN_CLOCK_MHZ_FIELD;
      ism_reg <= `REFSC_RST_IRQ_MASK;
      loop_divider_value_reg <= `REFSC_RST_LOOP_DIV;
      lo_div_reg <= `REFSC_RST_LO_DIV;
      lo_pwr_reg <= `REFSC_RST_LO_PWR;
      clk_div_reg <= `REFSC_RST_CLK_DIV;
    end else begin
      // Out-of-range codes are stored as written; the host owns range.
      if (hit(`REFSC_OFF_MCLK_MAIN_CLOCK_MHZ_FIELD)) mclk_main_clock_mhz_field_reg <= rx_reg[5:0];
      if (hit(`REFSC_OFF_IRQ_MASK)) ism_reg <= rx_reg[2:0];
      if (hit(`REFSC_OFF_LOOP_DIV)) loop_divider_value_reg <= rx_reg[6:0];
      if (hit(`REFSC_OFF_LO_DIV)) lo_div_reg <= rx_reg[4:0];
      if (hit(`REFSC_OFF_LO_PWR)) lo_pwr_reg <= rx_reg[3:0];
      if (hit(`REFSC_OFF_CLK_DIV)) clk_div_reg <= rx_reg[1:0];
    end
  end

  // General control; its calibration trigger self-clears on completion.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      gcr_reg <= `REFSC_RST_GEN_CTRL;
    end else if (soft_rst_reg) begin
      gcr_reg <= `REFSC_RST_GEN_CTRL;
    end else if (hit(`REFSC_OFF_GEN_CTRL)) begin
      gcr_reg <= rx_reg[7:0];
    end else if (EV_TUNE_DONE_IN) begin
      gcr_reg[`REFSC_GCR_CAL_BIT] <= 1'b0;
    end
  end

  // Events gated by their enables; a timeout counts as a retune event.
  assign ev_set = {EV_TUNE_DONE_IN, EV_CAL_TIMEOUT_IN, EV_MCLK_READY_IN}
                  & ise_reg;

  // Enables: a write loads them, then any bit whose status sets is
  // dropped in the same cycle so one event fires once per arming.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ise_reg <= `REFSC_RST_IRQ_EN;
    end else if (soft_rst_reg) begin
      ise_reg <= `REFSC_RST_IRQ_EN;
    end else if (hit(`REFSC_OFF_IRQ_EN)) begin
      ise_reg <= rx_reg[2:0] & ~ev_set;
    end else begin
      ise_reg <= ise_reg & ~ev_set;
    end
  end

  // Status is cleared by a read, but an event in that cycle survives.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      isr_reg <= 3'h0;
    end else if (soft_rst_reg) begin
      isr_reg <= 3'h0;
    end else begin
      isr_reg <= (isr_rd_reg ? 3'h0 : isr_reg) | ev_set;
    end
  end

  // Interrupt pin is a registered level, one cycle behind the status.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= ~|(isr_reg & ism_reg);
    end
  end

  // Calibration code registers feed the oscillator directly.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      bias_reg <= `REFSC_RST_BIAS;
      main_clock_mhz_field_reg <= `REFSC_RST_MAIN_CLOCK_MHZ_FIELD;
      amp_reg <= `REFSC_RST_AMP;
    end else if (soft_rst_reg) begin
      bias_reg <= `REFSC_RST_BIAS;
      main_clock_mhz_field_reg <= `REFSC_RST_MAIN_CLOCK_MHZ_FIELD;
      amp_reg <= `REFSC_RST_AMP;
    end else begin
      if (hit(`REFSC_OFF_BIAS_CODE)) bias_reg <= rx_reg[4:0];
      if (wr_hit_main_clock_mhz_field) main_clock_mhz_field_reg <= rx_reg[8:0];
      if (hit(`REFSC_OFF_AMP_CODE)) amp_reg <= rx_reg[5:0];
    end
  end

  // Readbacks follow a write, or take the calibrator's live results.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      bias_rb_reg <= `REFSC_RST_BIAS;
      main_clock_mhz_field_rb_reg <= `REFSC_RST_MAIN_CLOCK_MHZ_FIELD;
      amp_rb_reg <= `REFSC_RST_AMP;
    end else if (soft_rst_reg) begin
      bias_rb_reg <= `REFSC_RST_BIAS;
      main_clock_mhz_field_rb_reg <= `REFSC_RST_MAIN_CLOCK_MHZ_FIELD;
      amp_rb_reg <= `REFSC_RST_AMP;
    end else if (CAL_UPDATE_IN) begin
      bias_rb_reg <= CAL_BIAS_IN;
      main_clock_mhz_field_rb_reg <= CAL_MAIN_CLOCK_MHZ_FIELD_IN;
      amp_rb_reg <= CAL_AMP_IN;
    end else begin
      if (hit(`REFSC_OFF_BIAS_CODE)) bias_rb_reg <= rx_reg[4:0];
      if (wr_hit_main_clock_mhz_field) main_clock_mhz_field_rb_reg <= rx_reg[8:0];
      if (hit(`REFSC_OFF_AMP_CODE)) amp_rb_reg <= rx_reg[5:0];
    end
  end

  // Timeout flag: a new timeout wins over a clear in the same cycle.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      timeout_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= EV_CAL_TIMEOUT_IN
        | (timeout_reg & ~(CAL_START_IN | wr_hit_main_clock_mhz_field));
    end
  end

  // Control outputs come straight from their flops, except LO_DIVIDE_OUT, which is decoded from lo_div_reg.
  assign IRQ_N_OUT = irq_n_reg;
  assign GEN_CTRL_OUT = gcr_reg;
  assign MCLK_MAIN_CLOCK_MHZ_FIELD_OUT = mclk_main_clock_mhz_field_reg;
  assign LOOP_DIV_OUT = loop_divider_value_reg;
  assign LO_RATIO_OUT = lo_div_reg[3:0];
  assign LO_DIVIDE_OUT = lo_ratio(lo_div_reg[3:0]);
  assign LO_DRIVE_OUT = lo_pwr_reg;
  assign CLK_RATIO_OUT = clk_div_reg;
  assign BIAS_CODE_OUT = bias_reg;
  assign MAIN_CLOCK_MHZ_FIELD_CODE_OUT = main_clock_mhz_field_reg;
  assign AMP_CODE_OUT = amp_reg;

  // Checks that tie outputs and state to their causes.
  a_enable_gates_event: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) (!soft_rst_reg && !ise_reg[0] && !isr_rd_reg
    && !isr_reg[0]) |=> !isr_reg[0]) else $error("status set while disabled");
  a_status_drops_enable: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) (ev_set[1] && !soft_rst_reg)
    |=> isr_reg[1] && !ise_reg[1]) else $error("enable not dropped");
  a_irq_pin_low: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) (|(isr_reg & ism_reg)) |=> !IRQ_N_OUT)
    else $error("irq pin not low");
  a_irq_pin_high: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) !(|(isr_reg & ism_reg)) |=> IRQ_N_OUT)
    else $error("irq pin stuck low");
  a_read_clears_status: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) (isr_rd_reg && !soft_rst_reg)
    |=> isr_reg == $past(ev_set)) else $error("status not cleared");
  a_soft_reset_loads: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) soft_rst_reg |=> mclk_main_clock_mhz_field_reg == 6'h26
    && loop_divider_value_reg == 7'h1F && main_clock_mhz_field_reg == 9'h102 && lo_div_reg == 5'h03)
    else $error("defaults not restored");
  a_timeout_retune: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) (EV_CAL_TIMEOUT_IN && !soft_rst_reg)
    |=> timeout_reg && (isr_reg[1] || !$past(ise_reg[1])))
    else $error("timeout not recorded");
  a_timeout_clear: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) (CAL_START_IN && !EV_CAL_TIMEOUT_IN)
    |=> !timeout_reg) else $error("timeout not cleared");
  a_lo_ratio_decode: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) (LO_RATIO_OUT == 4'hF) |-> LO_DIVIDE_OUT == 5'h03)
    else $error("lo ratio decode wrong");
  a_miso_only_read: assert property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) csn_sync_reg[1] |=> !SPI_MISO_OE_OUT)
    else $error("reply driven while idle");

  c_status_read: cover property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) isr_rd_reg && |isr_reg);
  c_soft_reset: cover property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) soft_rst_reg);
  c_wide_write: cover property (@(posedge CLK_SYS_IN)
    disable iff (!RESETN_IN) wr_hit_main_clock_mhz_field);

endmodule

// File: verif/refsc_host.sv
`timescale 1ns/1ps
// Host model: a mode-0 serial master, MSB first. Each clock phase lasts six
// system clocks so the device's two-flop synchronisers never miss an edge.
module refsc_host (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic csn_out,
  output logic sclk_out,
  output logic mosi_out
);
  localparam int HALF = 6;

  // Idle with the frame deselected and the serial clock parked low.
  initial begin
    csn_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // One frame: address byte, then n data bits; reply bits gather in q.
  task automatic xfer(input logic [7:0] addr, input logic [15:0] data,
                      input int n, output logic [15:0] q);
    logic [23:0] sh;
    sh = {addr, data << (16 - n)};
    q = 16'h0000;
    tick(1);
    csn_out <= 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      tick(HALF);
      sclk_out <= 1'b0;
      mosi_out <= sh[23 - i];
      tick(HALF);
      sclk_out <= 1'b1;
      if (i >= 8) q = {q[14:0], miso_in};
    end
    tick(HALF);
    sclk_out <= 1'b0;
    mosi_out <= ~mosi_out; // Stale data would hide a missed edge.
    tick(HALF);
    csn_out <= 1'b1;
    tick(8);
  endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, cal_start, cal_update, csn, sclk, mosi, miso, irq_n;
  logic [2:0] ev;
  logic [3:0] osc_flags;
  logic [8:0] main_clock_mhz_field_code;
  logic [4:0] lo_div, bias_code;
  logic miso_drv, miso_oe;
  logic [7:0] gen_ctrl;
  logic [6:0] loop_div;
  logic [5:0] mclk_main_clock_mhz_field, amp_code;
  logic [3:0] lo_ratio, lo_drive;
  logic [1:0] clk_ratio;
  logic [15:0] q;
  int errors;
  int samples_checked;
  logic [7:0] rb_a [10] = '{8'hC6, 8'hC7, 8'hC8, 8'hCA, 8'hCB, 8'hCC,
                            8'hCD, 8'hD6, 8'hD9, 8'hDB};
  logic [15:0] rb_v [10] = '{16'h26, 16'h0, 16'h0, 16'h1F, 16'h3, 16'h0,
                             16'h0, 16'h20, 16'h10, 16'h102};
  logic [7:0] wa [6] = '{8'h76, 8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7D};
  logic [7:0] ra [6] = '{8'hC6, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
  logic [7:0] wv [6] = '{8'h0A, 8'h02, 8'h04, 8'h0F, 8'h0C, 8'h03};
  logic [4:0] lc [4] = '{5'h0, 5'h1, 5'hE, 5'hF};
  logic [4:0] ld [4] = '{5'h1, 5'h2, 5'h1C, 5'h3};

  refsc_host host (.clk_in(clk), .miso_in(miso), .csn_out(csn),
    .sclk_out(sclk), .mosi_out(mosi));

  refsc_top DUT (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .SPI_CSN_IN(csn),
    .SPI_SCLK_IN(sclk), .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso_drv),
    .SPI_MISO_OE_OUT(miso_oe), .EV_MCLK_READY_IN(ev[0]),
    .EV_TUNE_DONE_IN(ev[1]), .EV_CAL_TIMEOUT_IN(ev[2]),
    .CAL_START_IN(cal_start), .CAL_UPDATE_IN(cal_update),
    .CAL_BIAS_IN(5'h15), .CAL_MAIN_CLOCK_MHZ_FIELD_IN(9'h1C3), .CAL_AMP_IN(6'h2A),
    .OSC_FLAGS_IN(osc_flags), .IRQ_N_OUT(irq_n), .GEN_CTRL_OUT(gen_ctrl),
    .MCLK_MAIN_CLOCK_MHZ_FIELD_OUT(mclk_main_clock_mhz_field), .LOOP_DIV_OUT(loop_div),
    .LO_RATIO_OUT(lo_ratio), .LO_DIVIDE_OUT(lo_div),
    .LO_DRIVE_OUT(lo_drive), .CLK_RATIO_OUT(clk_ratio),
    .BIAS_CODE_OUT(bias_code), .MAIN_CLOCK_MHZ_FIELD_CODE_OUT(main_clock_mhz_field_code),
    .AMP_CODE_OUT(amp_code));

  // A released reply line shows the inverse, so a late enable is caught.
  assign miso = miso_oe ? miso_drv : ~miso_drv;

  // Free-running system clock, 10 ns period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input int n = 8);
    host.xfer(a, d, n, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                    input int n = 8);
    host.xfer(a, 16'h0000, n, q);
    check(q, exp);
  endtask

  // Event pulses last exactly one system clock, as the device expects.
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 3'b000;
    repeat (3) @(posedge clk);
  endtask

  task automatic defaults();
    for (int i = 0; i < 10; i++) begin
      rd(rb_a[i], rb_v[i], (i == 9) ? 16 : 8);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A stuck handshake must not hang the run; 60000 cycles is ample.
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  // Main sequence: each test is a run of register frames and events.
  initial begin
    rst_n = 1'b0;
    ev = 3'b000;
    cal_start = 1'b0;
    cal_update = 1'b0;
    osc_flags = 4'hA;
    errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(irq_n, 16'h1);
    defaults();
    $display("test defaults done");
    // Clock settings go in while the main clock is still off.
    for (int i = 0; i < 6; i++) begin
      wr(wa[i], {8'h00, wv[i]});
      rd(ra[i], {8'h00, wv[i]});
    end
    check(mclk_main_clock_mhz_field, 16'h000A);
    check(loop_div, 16'h0004);
    check(lo_drive, 16'h000C);
    check(clk_ratio, 16'h0003);
    for (int i = 0; i < 4; i++) begin
      wr(8'h7B, {11'h0, lc[i]});
      check(lo_div, ld[i]);
      check(lo_ratio, {11'h000, lc[i]});
    end
    wr(8'h0B, 16'h01AB, 16);
    check(main_clock_mhz_field_code, 16'h01AB);
    rd(8'hDB, 16'h01AB, 16);
    wr(8'h09, 16'h0007);
    check(bias_code, 16'h0007);
    rd(8'hD9, 16'h0007);
    wr(8'h2C, 16'h0031);
    check(amp_code, 16'h0031);
    rd(8'hD6, 16'h0031);
    wr(8'h75, 16'h0021);
    check(gen_ctrl, 16'h0021);
    rd(8'hC5, 16'h0021);
    $display("test writes done");
    wr(8'h77, 16'h0007);
    pulse(3'b001);
    rd(8'hC7, 16'h0006);
    check(irq_n, 16'h1);
    pulse(3'b100);
    check(irq_n, 16'h0);
    rd(8'hDB, 16'h81AB, 16);
    rd(8'hC9, 16'h0003);
    check(irq_n, 16'h1);
    pulse(3'b001);
    pulse(3'b010);
    rd(8'hC9, 16'h0004);
    rd(8'hC7, 16'h0000);
    $display("test interrupts done");
    @(posedge clk);
    cal_start <= 1'b1;
    cal_update <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    cal_update <= 1'b0;
    rd(8'hD9, 16'h0015);
    rd(8'hD6, 16'h002A);
    rd(8'hDB, 16'h01C3, 16);
    rd(8'h83, 16'h000A);
    osc_flags <= 4'h5;
    rd(8'h83, 16'h0005);
    $display("test calibration done");
    wr(8'h79, 16'h0000, 0);
    defaults();
    rd(8'hC5, 16'h0000);
    check(bias_code, 16'h0010);
    check(amp_code, 16'h0020);
    check(main_clock_mhz_field_code, 16'h0102);
    check(gen_ctrl, 16'h0000);
    $display("test reset command done");
    report_and_stop();
  end
endmodule
